//--- hw/pwc_wave_counter.sv
// Wave counter top: APB registers, shared counter and four compare outputs.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
module pwc_wave_counter
  import pwc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sequence_begin_task,
  input wire logic load_valid,
  input wire logic [15:0] load_word0,
  input wire logic [15:0] load_word1,
  input wire logic [15:0] load_word2,
  input wire logic [15:0] load_word3,
  output logic load_ready,
  output logic period_end,
  output logic [pwc_pkg::NCH-1:0] pwm_out
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic enable;
    logic count_up_then_down;
    logic load_layout_a;
    logic [CNT_W-1:0] counter_top_value;
    logic [PRESC_W-1:0] presc;
    pwc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] top_act;
    logic [NCH-1:0][CNT_W-1:0] cmp_act;
    logic [NCH-1:0] pol_act;
    logic [NCH-1:0][CNT_W-1:0] cmp_pend;
    logic [NCH-1:0] pol_pend;
    logic [CNT_W-1:0] top_pend;
    logic pend;
    logic [NCH-1:0] out;
    logic pend_end;
    logic [31:0] rdata;
  } pwc_st_t;
  pwc_st_t st_reg;
  pwc_st_t st_next;
  pwc_load_if ld ();
  logic tick;
  logic wr;
  logic rd;
  logic at_top;
  logic at_zero;
  logic at_wrap;
  logic [CNT_W-1:0] cmp_val;
  logic boundary;
  logic [NCH-1:0] level;
  assign ld.valid = load_valid;
  assign ld.word[0] = load_word0;
  assign ld.word[1] = load_word1;
  assign ld.word[2] = load_word2;
  assign ld.word[3] = load_word3;
  assign load_ready = ld.ready;
  ////////////////////////////////////////////////////////////////////////////
  pwc_prescaler #() u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(st_reg.state != PWC_IDLE),
    .presc(st_reg.presc),
    .tick(tick)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Zero-wait APB slave; addresses above ADDR_COUNT answer with an error.
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable && paddr > ADDR_COUNT) begin
      pslverr = 1'b1;
    end
  end
  assign prdata = st_reg.rdata;
  ////////////////////////////////////////////////////////////////////////////
  // A decoder load is taken only while no earlier load still waits.
  assign ld.ready = !st_reg.pend;
  assign at_top = st_reg.cnt >= st_reg.top_act;
  assign at_zero = st_reg.cnt == '0;
  // Up-only counting wraps one step before the top value, so a period is top ticks long.
  assign at_wrap = ({1'b0, st_reg.cnt} + 16'h0001) >= {1'b0, st_reg.top_act};
  // Rising half compares one step back, so each value shows twice per period.
  always_comb begin
    cmp_val = st_reg.cnt;
    if (st_reg.count_up_then_down && st_reg.state == PWC_UP && !at_zero) begin
      cmp_val = st_reg.cnt - 15'h0001;
    end
  end
  assign period_end = st_reg.pend_end;
  always_comb begin
    boundary = 1'b0;
    if (tick) begin
      if (st_reg.state == PWC_UP && !st_reg.count_up_then_down && at_wrap) begin
        boundary = 1'b1;
      end
      if (st_reg.state == PWC_DOWN && at_zero) begin
        boundary = 1'b1;
      end
    end
  end
  // Output level per channel for the current counter value.
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_comb begin
        if (st_reg.cmp_act[g] == '0) begin
          level[g] = st_reg.pol_act[g];
        end else if (st_reg.cmp_act[g] > st_reg.top_act) begin
          level[g] = st_reg.pol_act[g] ? 1'b0 : 1'b1;
        end else begin
          level[g] = (cmp_val < st_reg.cmp_act[g]) ^ st_reg.pol_act[g];
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.pend_end = 1'b0;
    st_next.rdata = ZERO_WORD;
    if (rd) begin
      case (paddr)
        ADDR_CTRL: begin
          st_next.rdata = 32'({st_reg.load_layout_a, st_reg.count_up_then_down, st_reg.enable});
        end
        ADDR_TOP: begin
          st_next.rdata = 32'(st_reg.counter_top_value);
        end
        ADDR_PRESC: begin
          st_next.rdata = 32'(st_reg.presc);
        end
        ADDR_STATUS: begin
          st_next.rdata = 32'({st_reg.pend, st_reg.state});
        end
        ADDR_COUNT: begin
          st_next.rdata = 32'(st_reg.cnt);
        end
        default: begin
          st_next.rdata = ZERO_WORD;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        ADDR_CTRL: begin
          st_next.enable = pwdata[CTRL_EN_BIT];
          st_next.count_up_then_down = pwdata[CTRL_UD_BIT];
          st_next.load_layout_a = pwdata[CTRL_WAVE_BIT];
        end
        ADDR_TOP: begin
          st_next.counter_top_value = pwdata[CNT_W-1:0];
        end
        ADDR_PRESC: begin
          st_next.presc = pwdata[PRESC_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Memory words are staged and never written by software.
    if (ld.valid && ld.ready) begin
      st_next.pend = 1'b1;
      for (int i = 0; i < NCH; i++) begin
        st_next.cmp_pend[i] = ld.word[i][CNT_W-1:0];
        st_next.pol_pend[i] = ld.word[i][POL_BIT];
      end
      if (st_reg.load_layout_a) begin
        st_next.top_pend = ld.word[WAVE_TOP_SLOT][CNT_W-1:0];
        st_next.cmp_pend[WAVE_TOP_SLOT] = '0;
        st_next.pol_pend[WAVE_TOP_SLOT] = 1'b0;
      end else begin
        st_next.top_pend = st_reg.counter_top_value;
      end
    end
    case (st_reg.state)
      PWC_IDLE: begin
        st_next.cnt = '0;
        if (st_reg.enable && sequence_begin_task && st_next.pend) begin
          st_next.state = PWC_UP;
          st_next.cmp_act = st_next.cmp_pend;
          st_next.pol_act = st_next.pol_pend;
          st_next.top_act = st_reg.load_layout_a ? st_next.top_pend
                                                 : st_reg.counter_top_value;
          st_next.pend = 1'b0;
        end
      end
      PWC_UP: begin
        if (tick) begin
          st_next.out = level;
          if (st_reg.count_up_then_down && at_top) begin
            st_next.state = PWC_DOWN;
            st_next.cnt = st_reg.cnt - 15'h0001;
          end else if (!st_reg.count_up_then_down && at_wrap) begin
            st_next.cnt = '0;
          end else begin
            st_next.cnt = st_reg.cnt + 15'h0001;
          end
        end
      end
      PWC_DOWN: begin
        if (tick) begin
          st_next.out = level;
          if (at_zero) begin
            st_next.state = PWC_UP;
            st_next.cnt = 15'h0001;
          end else begin
            st_next.cnt = st_reg.cnt - 15'h0001;
          end
        end
      end
      default: begin
        st_next.state = PWC_IDLE;
      end
    endcase
    if (boundary) begin
      st_next.pend_end = 1'b1;
      if (st_reg.pend) begin
        st_next.cmp_act = st_reg.cmp_pend;
        st_next.pol_act = st_reg.pol_pend;
        st_next.top_act = st_reg.top_pend;
        st_next.pend = 1'b0;
      end
      if (!st_reg.enable) begin
        st_next.state = PWC_IDLE;
        st_next.cnt = '0;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.counter_top_value <= TOP_RESET;
      st_reg.presc <= PRESC_RESET;
      st_reg.state <= PWC_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
  assign pwm_out = st_reg.out;
endmodule // pwc_wave_counter

//--- hw/pwc_pkg.sv
// Package of constants, register map and types for the wave counter block.
// Function
// - One shared 15-bit counter, four compare channels.
// - Software selects up or up-down counting.
// - Period from top value and prescaler.
// - Top below compare: no edges, output high.
// - Compare values loaded only from decoder path.
// - Top-value writes safe at any time.
// - Load_layout_a layout takes top value from memory.
// - Other layouts sample top at start, loads.
// - Up mode wraps to zero, edge-aligned pulses.
// - Compare zero stays low, top stays high.
// - Up period is top times prescaled clock.
// - Up-down mode counts down, center-aligned pulses.
// - Up-down period is twice top times clock.
// - Polarity comes from memory word.
// - Glitch-free memory updates every period.
// - Word bit 15 polarity, bits 14:0 compare.
// - Load_layout_a layout: three compares then top value.
package pwc_pkg;
  localparam int CNT_W = 15;
  localparam int NCH = 4;
  localparam int POL_BIT = 15;
  localparam int WAVE_TOP_SLOT = 3;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TOP = 12'h004;
  localparam logic [11:0] ADDR_PRESC = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_COUNT = 12'h010;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_UD_BIT = 1;
  localparam int CTRL_WAVE_BIT = 2;
  localparam logic [14:0] TOP_RESET = 15'h03E8;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam int PRESC_W = 3;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {
    PWC_IDLE = 2'b00,
    PWC_UP = 2'b01,
    PWC_DOWN = 2'b11
  } pwc_state_t;
endpackage

//--- hw/pwc_load_if.sv
// Interface carrying decoder load words into the wave counter.
interface pwc_load_if;
  logic valid;
  logic ready;
  logic [15:0] word [4];
  modport src (output valid, output word, input ready);
  modport dst (input valid, input word, output ready);
endinterface

//--- hw/pwc_prescaler.sv
// Prescaler producing a one-cycle tick every 2**presc base clocks.
module pwc_prescaler
  import pwc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [pwc_pkg::PRESC_W-1:0] presc,
  output logic tick
);
  typedef struct packed {
    logic [7:0] div;
  } pwc_pre_st_t;
  pwc_pre_st_t st_reg;
  pwc_pre_st_t st_next;
  logic [7:0] mask;
  always_comb begin
    mask = 8'(({1'b1, 7'h00} >> (7 - presc)) - 1);
    tick = run && ((st_reg.div & mask) == mask);
  end
  always_comb begin
    st_next = st_reg;
    if (!run) begin
      st_next.div = 8'h00;
    end else begin
      st_next.div = st_reg.div + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // pwc_prescaler

//--- testbench/pwc_pins_model.sv
// Load model on the channel pins: high time and length of each period.
module pwc_pins_model (
  input wire logic pclk,
  input wire logic period_end,
  input wire logic [3:0] pins,
  output logic [15:0] len_last,
  output logic [15:0] hi_last [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] len;
  logic [15:0] hi [4];
  always @(posedge pclk) begin
    len <= period_end ? 16'h1 : len + 16'h1;
    if (period_end) len_last <= len;
    for (int i = 0; i < 4; i++) begin
      hi[i] <= period_end ? 16'(pins[i]) : hi[i] + 16'(pins[i]);
      if (period_end) hi_last[i] <= hi[i];
    end
  end
endmodule // pwc_pins_model

//--- testbench/pwc_wave_counter_assertions.sv
// Port checker of the wave counter, bound to its top module.
module pwc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic load_valid,
  input wire logic load_ready,
  input wire logic period_end,
  input wire logic [pwc_pkg::NCH-1:0] pwm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc; psel && penable; endsequence
  sequence unmap; acc ##0 (paddr > pwc_pkg::ADDR_COUNT); endsequence
  ready_a: assert property (acc |-> pready) else $error("Access not ready.");
  unmap_err_a: assert property (unmap |-> pslverr) else $error("No error flag.");
  map_ok_a: assert property (acc ##0 (paddr <= pwc_pkg::ADDR_COUNT) |-> !pslverr)
    else $error("Spurious error flag.");
  unmap_rd_a: assert property (unmap ##0 !pwrite |-> prdata == pwc_pkg::ZERO_WORD)
    else $error("Unmapped read not zero.");
  idle_err_a: assert property (!psel |-> !pslverr) else $error("Error flag when idle.");
  load_take_a: assert property (load_valid && load_ready |=> !load_ready)
    else $error("Load not held.");
  pulse_one_a: assert property (period_end |=> !period_end)
    else $error("Boundary pulse too long.");
  rst_quiet_a: assert property ($rose(presetn) |-> pwm_out == '0 && !period_end)
    else $error("Outputs active after reset.");
endmodule // pwc_checker

bind pwc_wave_counter pwc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .load_valid(load_valid), .load_ready(load_ready),
  .period_end(period_end), .pwm_out(pwm_out));

//--- testbench/tb_top.sv
// Self-checking bench of the wave counter.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwc_pkg::*;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, lv = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, e_v;
  logic pready, pslverr, load_ready, period_end;
  logic [15:0] lw [4] = '{default: '0};
  logic [3:0] pwm;
  logic [15:0] len_last, r, lfsr = 16'h9E28;
  logic [15:0] hi_last [4];
  logic [31:0] exp_q [$];
  int failures = 0, checks_done = 0;
  always #4 pclk = ~pclk;
  pwc_wave_counter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sequence_begin_task(go), .load_valid(lv), .load_word0(lw[0]),
    .load_word1(lw[1]), .load_word2(lw[2]), .load_word3(lw[3]), .load_ready(load_ready),
    .period_end(period_end), .pwm_out(pwm));
  pwc_pins_model u_pins (.pclk(pclk), .period_end(period_end), .pins(pwm),
    .len_last(len_last), .hi_last(hi_last));
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wt(ref logic s, input int lim);
    int n;
    n = 0;
    do begin @(posedge pclk); n++; end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) begin failures++; close_out(); end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    wt(pready, 50);
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    exp_q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  task automatic load(logic [15:0] a, b, c, d);
    @(posedge pclk);
    lv <= 1; lw <= '{a, b, c, d};
    wt(load_ready, 5000);
    lv <= 0;
  endtask
  task automatic meas(logic [15:0] l, a, b, c, d);
    repeat (3) wt(period_end, 9000);
    @(negedge pclk);
    `CHK("period", l, len_last)
    `CHK("ch0", a, hi_last[0])
    `CHK("ch1", b, hi_last[1])
    `CHK("ch2", c, hi_last[2])
    `CHK("ch3", d, hi_last[3])
  endtask
  always @(posedge pclk) if (psel && penable && !pwrite && pready) begin
    e_v = exp_q.pop_front();
    `CHK("prdata", e_v, prdata)
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(ADDR_CTRL, ZERO_WORD);
    rd(ADDR_TOP, {17'h0, TOP_RESET});
    rd(ADDR_PRESC, ZERO_WORD);
    rd(12'h014, ZERO_WORD);
    apb(1, 12'h020, 32'h5);
    $display("test registers done");
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    r = lfsr % 16'd19 + 16'd1;
    apb(1, ADDR_TOP, 32'd20);
    apb(1, ADDR_CTRL, 32'h1);
    load(16'h0, 16'd20, 16'd7, 16'h8000 | r);
    go <= 1;
    @(posedge pclk);
    go <= 0;
    meas(20, 0, 20, 7, 20 - r);
    apb(1, ADDR_PRESC, 32'h1);
    load(16'd25, 16'd3, 16'd7, 16'h0);
    meas(40, 40, 6, 14, 0);
    $display("test up mode done");
    apb(1, ADDR_PRESC, 32'h0);
    apb(1, ADDR_CTRL, 32'h3);
    load(16'h0, 16'd5, 16'd7, 16'h8000 | r);
    meas(40, 0, 10, 14, 40 - 2 * r);
    apb(1, ADDR_TOP, 32'd16);
    meas(40, 0, 10, 14, 40 - 2 * r);
    load(16'h0, 16'd5, 16'd7, 16'h0);
    meas(32, 0, 10, 14, 0);
    $display("test up-down mode done");
    apb(1, ADDR_CTRL, 32'h5);
    load(16'd3, 16'd5, 16'd9, 16'd12);
    meas(12, 3, 5, 9, 0);
    $display("test layout done");
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(ADDR_CTRL, ZERO_WORD);
    $display("test second reset done");
    close_out();
  end
endmodule // tb_top
